/* hdl/pss_supervisor.v */
/*
 sleep/wake supervisor with tuning registers behind an apb slave.
 assumes inputs synchronous to clk; speed in 0.1 Hz, pv and setpoint
 signed hundredths; motor ramp done by outside drive, reported back.
*/
// Design decisions made here: register access over APB and the register addresses.
`include "pss_regs.vh"

// What this block does
// - gains 0.00 to 99.99, default 1.00
// - sample period 0.050-9.999 s, default 0.100
// - setpoint first-order filter, default 0.150 s
// - sleep/wake only when enabled and automatic
// - keep sampling process variable while asleep
// - wake when pv below setpoint minus deviation, above setpoint plus it if reverse
// - start after wake held for wake delay
// - wake timer clears when condition drops
// - power-up run plus wake starts immediately
// - sleep threshold 0.0-400.0 Hz, default 0.0
// - zero threshold disables sleep entirely
// - stop after speed below threshold sleep delay
// - sleep-active alarm while asleep
// - run without wake stays asleep
// - ramp to minimum speed before loop control
// - sleep decelerates to 0 Hz and holds
// - mode 0 manual, 1 auto, 2 input
module pss_supervisor #(
	parameter CLK_NS = `PSS_CLK_NS,
	parameter TICK_MS = 1
) (
	input wire clk,
	input wire sys_rst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// drive side
	input wire run_stop_input,
	input wire manual_auto_input,
	input wire [15:0] motor_speed,
	input wire signed [15:0] process_variable,
	// outputs
	output reg motor_run,
	output reg ramp_to_min,
	output reg [15:0] speed_target,
	output reg loop_active,
	output reg loop_sample,
	output reg signed [15:0] filtered_setpoint,
	output reg sleep_active_alarm,
	output wire irq
);
	localparam integer TICK_FULL = (TICK_MS * `PSS_MS_NS) / CLK_NS;
	localparam [15:0] TICK_CYC = TICK_FULL[15:0];
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_SLEEP = 2'h1;
	localparam [1:0] ST_RAMP = 2'h2;
	localparam [1:0] ST_RUN = 2'h3;

	reg [3:0] ctrl;
	reg [15:0] integral_gain;
	reg [15:0] derivative_gain;
	reg [15:0] loop_sample_period;
	reg [15:0] setpoint_filter_time_constant;
	reg signed [15:0] wake_deviation;
	reg [15:0] wake_delay;
	reg [15:0] sleep_speed_threshold;
	reg [15:0] sleep_delay;
	reg [15:0] minimum_motor_speed;
	reg signed [15:0] setpoint;
	reg [1:0] irq_stat;
	reg [1:0] irq_mask;
	reg [1:0] state;
	reg [15:0] ms_div;
	reg [6:0] tenth_div;
	reg [15:0] period_cnt;
	reg [15:0] wake_cnt;
	reg [15:0] sleep_cnt;
	reg powerup;
	reg [1:0] next_state;

	wire wr = psel & penable & pwrite;
	wire ms_tick = (ms_div == TICK_CYC - 16'h0001);
	wire tenth_tick = ms_tick & (tenth_div == `PSS_TENTH_LAST);
	wire [1:0] mode = ctrl[`PSS_CTRL_MODE_HI:`PSS_CTRL_MODE_LO];
	reg auto_mode;
	reg signed [17:0] wake_lim;
	reg wake_cond;
	wire supervise;
	wire sleep_en = (sleep_speed_threshold != `PSS_RST_SPDTH);
	wire slow = motor_speed < sleep_speed_threshold;
	wire wake_done = wake_cond & (wake_cnt >= wake_delay);
	wire sleep_done = slow & (sleep_cnt >= sleep_delay);

	// clamp a written value into lo..hi
	function [15:0] clampu;
		input [15:0] v;
		input [15:0] lo;
		input [15:0] hi;
		begin
			clampu = (v < lo) ? lo : ((v > hi) ? hi : v);
		end
	endfunction

	function signed [15:0] clamps;
		input signed [15:0] v;
		begin
			if (v > $signed(`PSS_RST_GAIN_MAX))
				clamps = `PSS_RST_GAIN_MAX;
			else if (v < -$signed(`PSS_RST_GAIN_MAX))
				clamps = -$signed(`PSS_RST_GAIN_MAX);
			else
				clamps = v;
		end
	endfunction

	always @* begin
		case (mode)
		`PSS_MODE_MANUAL: auto_mode = 1'b0;
		`PSS_MODE_AUTO: auto_mode = 1'b1;
		default: auto_mode = manual_auto_input;
		endcase
	end

	assign supervise = ctrl[`PSS_CTRL_LOOP_EN] & auto_mode;

	// pv compared every cycle, asleep or not
	always @* begin
		if (ctrl[`PSS_CTRL_REVERSE]) begin
			wake_lim = filtered_setpoint + wake_deviation;
			wake_cond = process_variable > wake_lim;
		end else begin
			wake_lim = filtered_setpoint - wake_deviation;
			wake_cond = process_variable < wake_lim;
		end
	end

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign irq = |(irq_stat & irq_mask);

	// register writes; values out of range clamp to the limits
	always @(posedge clk) begin
		if (sys_rst) begin
			ctrl <= `PSS_RST_CTRL;
			integral_gain <= `PSS_RST_GAIN;
			derivative_gain <= `PSS_RST_GAIN;
			loop_sample_period <= `PSS_RST_PERIOD;
			setpoint_filter_time_constant <= `PSS_RST_FILT;
			wake_deviation <= `PSS_RST_WDEV;
			wake_delay <= `PSS_RST_WDLY;
			sleep_speed_threshold <= `PSS_RST_SPDTH;
			sleep_delay <= `PSS_RST_SDLY;
			minimum_motor_speed <= 16'h0000;
			setpoint <= 16'h0000;
			irq_mask <= 2'h0;
		end else if (wr) begin
			if (paddr == `PSS_OFF_CTRL)
				ctrl <= pwdata[3:0];
			else if (paddr == `PSS_OFF_IGAIN)
				integral_gain <= clampu(pwdata[15:0], 16'h0000,
					`PSS_RST_GAIN_MAX);
			else if (paddr == `PSS_OFF_DGAIN)
				derivative_gain <= clampu(pwdata[15:0], 16'h0000,
					`PSS_RST_GAIN_MAX);
			else if (paddr == `PSS_OFF_PERIOD)
				loop_sample_period <= clampu(pwdata[15:0],
					`PSS_PERIOD_MIN, `PSS_TIME_MAX);
			else if (paddr == `PSS_OFF_FILT)
				setpoint_filter_time_constant <= clampu(pwdata[15:0],
					16'h0000, `PSS_TIME_MAX);
			else if (paddr == `PSS_OFF_WDEV)
				wake_deviation <= clamps(pwdata[15:0]);
			else if (paddr == `PSS_OFF_WDLY)
				wake_delay <= clampu(pwdata[15:0], 16'h0000,
					`PSS_TIME_MAX);
			else if (paddr == `PSS_OFF_SPDTH)
				sleep_speed_threshold <= clampu(pwdata[15:0], 16'h0000,
					`PSS_SPDTH_MAX);
			else if (paddr == `PSS_OFF_SDLY)
				sleep_delay <= clampu(pwdata[15:0], 16'h0000,
					`PSS_TIME_MAX);
			else if (paddr == `PSS_OFF_MINSPD)
				minimum_motor_speed <= pwdata[15:0];
			else if (paddr == `PSS_OFF_SETPT)
				setpoint <= pwdata[15:0];
			else if (paddr == `PSS_OFF_MASK)
				irq_mask <= pwdata[1:0];
		end
	end

	// read mux; unmapped addresses read zero
	always @(posedge clk) begin
		if (sys_rst)
			prdata <= 32'h0000_0000;
		else if (psel & ~penable & ~pwrite) begin
			if (paddr == `PSS_OFF_CTRL)
				prdata <= {28'h0, ctrl};
			else if (paddr == `PSS_OFF_IGAIN)
				prdata <= {16'h0, integral_gain};
			else if (paddr == `PSS_OFF_DGAIN)
				prdata <= {16'h0, derivative_gain};
			else if (paddr == `PSS_OFF_PERIOD)
				prdata <= {16'h0, loop_sample_period};
			else if (paddr == `PSS_OFF_FILT)
				prdata <= {16'h0, setpoint_filter_time_constant};
			else if (paddr == `PSS_OFF_WDEV)
				prdata <= {16'h0, wake_deviation};
			else if (paddr == `PSS_OFF_WDLY)
				prdata <= {16'h0, wake_delay};
			else if (paddr == `PSS_OFF_SPDTH)
				prdata <= {16'h0, sleep_speed_threshold};
			else if (paddr == `PSS_OFF_SDLY)
				prdata <= {16'h0, sleep_delay};
			else if (paddr == `PSS_OFF_MINSPD)
				prdata <= {16'h0, minimum_motor_speed};
			else if (paddr == `PSS_OFF_SETPT)
				prdata <= {16'h0, setpoint};
			else if (paddr == `PSS_OFF_STATUS)
				prdata <= {27'h0, wake_cond, sleep_active_alarm,
					loop_active, state};
			else if (paddr == `PSS_OFF_IRQ)
				prdata <= {30'h0, irq_stat};
			else if (paddr == `PSS_OFF_MASK)
				prdata <= {30'h0, irq_mask};
			else
				prdata <= 32'h0000_0000;
		end
	end

	// time base: ms tick and 0.1 s tick
	always @(posedge clk) begin
		if (sys_rst) begin
			ms_div <= 16'h0000;
			tenth_div <= 7'h00;
		end else if (ms_tick) begin
			ms_div <= 16'h0000;
			tenth_div <= (tenth_div == `PSS_TENTH_LAST) ? 7'h00 :
				tenth_div + 7'h01;
		end else
			ms_div <= ms_div + 16'h0001;
	end

	// loop sample strobe every period ms
	always @(posedge clk) begin
		if (sys_rst) begin
			period_cnt <= 16'h0000;
			loop_sample <= 1'b0;
		end else begin
			loop_sample <= 1'b0;
			if (ms_tick) begin
				if (period_cnt + 16'h0001 >= loop_sample_period) begin
					period_cnt <= 16'h0000;
					loop_sample <= 1'b1;
				end else
					period_cnt <= period_cnt + 16'h0001;
			end
		end
	end

	// first-order filter, one step per ms: y += (x-y)*1/(tau+1)
	// coarse divide by shift keeps it small; tau 0 passes straight
	reg signed [16:0] filt_err;
	reg [3:0] filt_sh;
	reg signed [16:0] filt_step;
	always @* begin
		filt_err = setpoint - filtered_setpoint;
		if (setpoint_filter_time_constant < 16'h0002) filt_sh = 4'h0;
		else if (setpoint_filter_time_constant < 16'h0004) filt_sh = 4'h1;
		else if (setpoint_filter_time_constant < 16'h0010) filt_sh = 4'h3;
		else if (setpoint_filter_time_constant < 16'h0040) filt_sh = 4'h5;
		else if (setpoint_filter_time_constant < 16'h0100) filt_sh = 4'h7;
		else if (setpoint_filter_time_constant < 16'h0400) filt_sh = 4'h9;
		else filt_sh = 4'hc;
		// small positive errors step half way so the output still lands exactly
		if ((filt_err >>> filt_sh) == 17'sh0)
			filt_step = filt_err - (filt_err >>> 1);
		else
			filt_step = filt_err >>> filt_sh;
	end
	always @(posedge clk) begin
		if (sys_rst)
			filtered_setpoint <= 16'h0000;
		else if (ms_tick) begin
			if (filt_sh == 4'h0)
				filtered_setpoint <= setpoint;
			else
				filtered_setpoint <= filtered_setpoint
					+ filt_step[15:0];
		end
	end

	// state machine
	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (run_stop_input & powerup & supervise & sleep_en & wake_cond)
				next_state = ST_RAMP;
			else if (run_stop_input & supervise & sleep_en)
				next_state = ST_SLEEP;
			else if (run_stop_input)
				next_state = ST_RUN;
		end
		ST_SLEEP: begin
			if (~run_stop_input)
				next_state = ST_IDLE;
			else if (~supervise | ~sleep_en)
				next_state = ST_RUN;
			else if (wake_done)
				next_state = ST_RAMP;
		end
		ST_RAMP: begin
			if (~run_stop_input)
				next_state = ST_IDLE;
			else if (motor_speed >= minimum_motor_speed)
				next_state = ST_RUN;
		end
		default: begin
			if (~run_stop_input)
				next_state = ST_IDLE;
			else if (supervise & sleep_en & sleep_done)
				next_state = ST_SLEEP;
		end
		endcase
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			powerup <= 1'b1;
			wake_cnt <= 16'h0000;
			sleep_cnt <= 16'h0000;
			irq_stat <= 2'h0;
		end else begin
			state <= next_state;
			if (state != ST_IDLE)
				powerup <= 1'b0;
			if (state != ST_SLEEP | ~wake_cond)
				wake_cnt <= 16'h0000;
			else if (tenth_tick & ~wake_done)
				wake_cnt <= wake_cnt + 16'h0001;
			if (state != ST_RUN | ~slow)
				sleep_cnt <= 16'h0000;
			else if (tenth_tick & ~sleep_done)
				sleep_cnt <= sleep_cnt + 16'h0001;
			// set wins over write-one-to-clear
			irq_stat <= (irq_stat & ~((wr & (paddr == `PSS_OFF_IRQ)) ?
				pwdata[1:0] : 2'h0)) |
				{(state == ST_SLEEP) & (next_state == ST_RAMP),
				(state != ST_SLEEP) & (next_state == ST_SLEEP)};
		end
	end

	// registered drive outputs
	always @(posedge clk) begin
		if (sys_rst) begin
			motor_run <= 1'b0;
			ramp_to_min <= 1'b0;
			speed_target <= 16'h0000;
			loop_active <= 1'b0;
			sleep_active_alarm <= 1'b0;
		end else begin
			motor_run <= (next_state == ST_RAMP) | (next_state == ST_RUN);
			ramp_to_min <= next_state == ST_RAMP;
			speed_target <= (next_state == ST_RAMP) ?
				minimum_motor_speed : 16'h0000;
			loop_active <= next_state == ST_RUN;
			sleep_active_alarm <= next_state == ST_SLEEP;
		end
	end
endmodule // pss_supervisor

/* inc/pss_regs.vh */
/*
 header of register offsets, field positions, reset values and timing
 figures for the sleep/wake supervisor; assumes a 20 MHz clock and APB.
*/
`ifndef PSS_REGS_VH
`define PSS_REGS_VH
// register byte offsets
`define PSS_OFF_CTRL 12'h000
`define PSS_OFF_IGAIN 12'h004
`define PSS_OFF_DGAIN 12'h008
`define PSS_OFF_PERIOD 12'h00c
`define PSS_OFF_FILT 12'h010
`define PSS_OFF_WDEV 12'h014
`define PSS_OFF_WDLY 12'h018
`define PSS_OFF_SPDTH 12'h01c
`define PSS_OFF_SDLY 12'h020
`define PSS_OFF_MINSPD 12'h024
`define PSS_OFF_SETPT 12'h028
`define PSS_OFF_STATUS 12'h02c
`define PSS_OFF_IRQ 12'h030
`define PSS_OFF_MASK 12'h034
// ctrl fields
`define PSS_CTRL_LOOP_EN 0
`define PSS_CTRL_REVERSE 1
`define PSS_CTRL_MODE_LO 2
`define PSS_CTRL_MODE_HI 3
// loop operation select codes
`define PSS_MODE_MANUAL 2'h0
`define PSS_MODE_AUTO 2'h1
`define PSS_MODE_INPUT 2'h2
// reset values, hundredths / milliseconds / tenths
`define PSS_RST_GAIN 16'h0064
`define PSS_RST_GAIN_MAX 16'h270f
`define PSS_RST_PERIOD 16'h0064
`define PSS_PERIOD_MIN 16'h0032
`define PSS_TIME_MAX 16'h270f
`define PSS_RST_FILT 16'h0096
`define PSS_RST_WDEV 16'h001e
`define PSS_RST_WDLY 16'h0032
`define PSS_RST_SPDTH 16'h0000
`define PSS_SPDTH_MAX 16'h0fa0
`define PSS_RST_SDLY 16'h0064
`define PSS_RST_CTRL 4'h9
// irq bits
`define PSS_IRQ_SLEEP 0
`define PSS_IRQ_WAKE 1
// time base: one millisecond and the clock period, in ns
`define PSS_MS_NS 1000000
`define PSS_CLK_NS 50
// last ms count of a tenth second
`define PSS_TENTH_LAST 7'h63
`endif

/* verif/pss_checker_assertions.sv */
/* assertions on the supervisor's drive-side outputs.
 assumes one clock and a synchronous reset, top ports only. */
module pss_checker (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// drive side
	input wire run_stop_input,
	input wire motor_run,
	input wire ramp_to_min,
	input wire [15:0] speed_target,
	input wire loop_active,
	input wire loop_sample,
	input wire sleep_active_alarm
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// outputs are registered after the decision, so allow the lag
	sequence s_cmd_off;
		!run_stop_input [*4];
	endsequence
	sequence s_lone_pulse;
		##1 !loop_sample [*8];
	endsequence
	a_asleep_stopped: assert property (
		sleep_active_alarm |-> !motor_run && speed_target == 16'h0000)
		else $error("asleep while motor driven");
	a_ramp_excludes_loop: assert property (
		ramp_to_min |-> motor_run && !loop_active)
		else $error("loop active during ramp");
	a_ramp_hands_loop: assert property (
		$fell(ramp_to_min) && motor_run |-> loop_active)
		else $error("ramp ended without loop");
	a_loop_awake: assert property (
		loop_active |-> motor_run && !sleep_active_alarm)
		else $error("loop active while asleep");
	a_wake_ramps: assert property (
		$fell(sleep_active_alarm) && motor_run |-> ramp_to_min)
		else $error("wake skipped the ramp");
	a_idle_target: assert property (
		!ramp_to_min |-> speed_target == 16'h0000)
		else $error("speed target outside ramp");
	a_sample_lone: assert property (
		loop_sample |-> s_lone_pulse)
		else $error("sample pulses too close");
	a_stop_on_cmd: assert property (
		s_cmd_off |-> !motor_run)
		else $error("motor on without run command");
endmodule // pss_checker
bind pss_supervisor pss_checker u_chk (.clk, .sys_rst, .run_stop_input,
	.motor_run, .ramp_to_min, .speed_target, .loop_active, .loop_sample,
	.sleep_active_alarm);

/* verif/pss_drive_model.sv */
/* drive and process model at the supervisor's far side.
 assumes bench requests change off the clock edge. */
module pss_drive_model (
	// clock
	input wire clk,
	// bench requests
	input wire run_req,
	input wire auto_req,
	input wire [15:0] pv_goal,
	input wire [15:0] spd_goal,
	// supervisor commands
	input wire motor_run,
	input wire loop_active,
	input wire [15:0] speed_target,
	// feedback
	output logic run_stop_input = 1'b1,
	output logic manual_auto_input = 1'b1,
	output logic [15:0] motor_speed = 16'h0000,
	output logic [15:0] process_variable = 16'hff9c
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] goal;
	assign goal = !motor_run ? 16'h0000 : loop_active ? spd_goal : speed_target;
	// speed slews a step a cycle, never jumps like a real drive
	always @(posedge clk) begin
		run_stop_input <= run_req;
		manual_auto_input <= auto_req;
		process_variable <= pv_goal;
		if (motor_speed < goal)
			motor_speed <= motor_speed + 16'h0001;
		else if (motor_speed > goal)
			motor_speed <= motor_speed - 16'h0001;
	end
endmodule // pss_drive_model

/* verif/pss_supervisor_test.sv */
/* self-checking bench of the supervisor.
 assumes 1 ms per clock via CLK_NS, apb with zero wait states. */
module pss_supervisor_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic pready, pslverr, irq, motor_run, ramp_to_min, loop_active;
	logic loop_sample, sleep_active_alarm, run_stop_input, manual_auto_input;
	logic [15:0] speed_target, motor_speed, filtered_setpoint, process_variable;
	logic run_req = 1'b1, auto_req = 1'b1;
	logic [15:0] pv_goal = 16'hff9c, spd_goal = 16'h0014;
	int fails = 0, comparisons = 0, n, k, cyc = 0;
	always #25 clk = ~clk;
	pss_supervisor #(.CLK_NS(1000000)) dut (.clk, .sys_rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .run_stop_input,
		.manual_auto_input, .motor_speed, .process_variable, .motor_run,
		.ramp_to_min, .speed_target, .loop_active, .loop_sample,
		.filtered_setpoint, .sleep_active_alarm, .irq);
	pss_drive_model model (.clk, .run_req, .auto_req, .pv_goal, .spd_goal,
		.motor_run, .loop_active, .speed_target, .run_stop_input,
		.manual_auto_input, .motor_speed, .process_variable);
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task tally_and_finish;
		if (fails == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task t_powerup;
		for (n = 0; n < 20 && motor_run !== 1'b1; n++) @(negedge clk);
		chk("powerup run", motor_run, 1'h1);
	endtask
	task t_regs;
		logic [11:0] a[10] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010,
			12'h014, 12'h018, 12'h01c, 12'h020, 12'h0fc};
		logic [15:0] e[10] = '{16'h0009, 16'h0064, 16'h0064, 16'h0064,
			16'h0096, 16'h001e, 16'h0032, 16'h0000, 16'h0064, 16'h0000};
		apb(1'b1, 12'h0fc, 32'hffff);
		for (int i = 0; i < 10; i++) begin
			apb(1'b0, a[i], 32'h0);
			chk("reset", rd, e[i]);
		end
		apb(1'b1, 12'h004, 32'h2710);
		apb(1'b0, 12'h004, 32'h0);
		chk("gain clamp", rd, 32'h270f);
		apb(1'b1, 12'h00c, 32'h0010);
		apb(1'b0, 12'h00c, 32'h0);
		chk("period clamp", rd, 32'h0032);
	endtask
	task t_sample;
		for (n = 0; n < 200 && loop_sample !== 1'b1; n++) @(negedge clk);
		repeat (2) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (loop_sample !== 1'b1 && n < 200);
		end
		chk("sample gap", n, 32'h32);
	endtask
	task t_sleep;
		apb(1'b1, 12'h018, 32'h2);
		apb(1'b1, 12'h020, 32'h3);
		apb(1'b1, 12'h024, 32'h32);
		apb(1'b1, 12'h028, 32'h0);
		apb(1'b1, 12'h034, 32'h1);
		pv_goal <= 16'h0000;
		for (n = 0; n < 300 && loop_active !== 1'b1; n++) @(negedge clk);
		apb(1'b1, 12'h01c, 32'h64);
		repeat (50) @(negedge clk);
		chk("early sleep", sleep_active_alarm, 1'h0);
		spd_goal <= 16'h0078;
		repeat (100) @(negedge clk);
		spd_goal <= 16'h0014;
		repeat (150) @(negedge clk);
		chk("sleep timer clear", sleep_active_alarm, 1'h0);
		for (n = 0; n < 400 && sleep_active_alarm !== 1'b1; n++) @(negedge clk);
		chk("alarm", sleep_active_alarm, 1'h1);
		chk("stopped", motor_run, 1'h0);
		chk("irq", irq, 1'h1);
		apb(1'b1, 12'h030, 32'h3);
		@(negedge clk);
		chk("irq clear", irq, 1'h0);
		pv_goal <= 16'hff9c;
		k = 0;
		repeat (90) begin
			@(negedge clk);
			k += loop_sample;
		end
		chk("asleep sampling", k != 0, 1'h1);
		pv_goal <= 16'h0000;
		repeat (20) @(negedge clk);
		pv_goal <= 16'hff9c;
		repeat (90) @(negedge clk);
		chk("wake restart", sleep_active_alarm, 1'h1);
		for (n = 0; n < 300 && ramp_to_min !== 1'b1; n++) @(negedge clk);
		chk("ramp", ramp_to_min, 1'h1);
		chk("ramp target", speed_target, 16'h0032);
		for (n = 0; n < 300 && loop_active !== 1'b1; n++) @(negedge clk);
		chk("loop after ramp", loop_active, 1'h1);
	endtask
	task t_manual;
		auto_req <= 1'b0;
		pv_goal <= 16'h0000;
		repeat (500) @(negedge clk);
		chk("input manual", sleep_active_alarm, 1'h0);
		apb(1'b1, 12'h000, 32'h1);
		auto_req <= 1'b1;
		repeat (500) @(negedge clk);
		chk("manual sleep", sleep_active_alarm, 1'h0);
		apb(1'b1, 12'h010, 32'h4);
		apb(1'b1, 12'h028, 32'h400);
		repeat (100) @(negedge clk);
		chk("setpoint filter", filtered_setpoint, 16'h0400);
		apb(1'b0, 12'h02c, 32'h0);
		chk("direct wake", rd[4], 1'h1);
		apb(1'b1, 12'h000, 32'h3);
		apb(1'b0, 12'h02c, 32'h0);
		chk("reverse idle", rd[4], 1'h0);
		pv_goal <= 16'h0500;
		apb(1'b0, 12'h02c, 32'h0);
		chk("reverse wake", rd[4], 1'h1);
	endtask
	task t_reboot;
		run_req <= 1'b0;
		pv_goal <= 16'hff9c;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		apb(1'b1, 12'h01c, 32'h64);
		apb(1'b1, 12'h024, 32'h32);
		@(negedge clk);
		chk("run off", motor_run, 1'h0);
		@(posedge clk);
		run_req <= 1'b1;
		for (n = 0; n < 20 && motor_run !== 1'b1; n++) @(negedge clk);
		chk("instant start", ramp_to_min, 1'h1);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		t_powerup;
		t_regs;
		t_sample;
		t_sleep;
		t_manual;
		t_reboot;
		tally_and_finish;
	end
endmodule // pss_supervisor_test
